/* include/dsif_pkg.sv */
`default_nettype none
package dsif_pkg;
	// Clock rate and counter width
	localparam int CLK_KHZ = 10000;
	localparam int CNT_W = 20;
	localparam int MON_W = CNT_W + 3;
	// Monitoring window is this many tolerance times
	localparam int MON_MULT = 5;
	// Test pulse lengths of a driving fail-safe output, in microseconds
	localparam int BRIGHT_TEST_US = 1000;
	localparam int DARK_TEST_US = 4000;
	localparam int BRIGHT_TEST_CYC = (BRIGHT_TEST_US * CLK_KHZ) / 1000;
	localparam int DARK_TEST_CYC = (DARK_TEST_US * CLK_KHZ) / 1000;
	// Reset values of the times, in microseconds and cycles
	localparam int DISC_TOL_RST_US = 500;
	localparam int DISC_TOL_RST_CYC = (DISC_TOL_RST_US * CLK_KHZ + 999) / 1000;
	localparam int SAFE_DEB_RST_CYC = DARK_TEST_CYC + BRIGHT_TEST_CYC;
	localparam int STD_DEB_RST_CYC = BRIGHT_TEST_CYC;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] TOL_OFS = 8'h04;
	localparam logic [7:0] SDEB_OFS = 8'h08;
	localparam logic [7:0] STDDEB_OFS = 8'h0c;
	localparam logic [7:0] STATE_OFS = 8'h10;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h18;
	// Reset values
	localparam logic CTRL_BASIC_RST = 1'b1;
	localparam logic CTRL_FORCE_RST = 1'b1;
	localparam logic [2:0] IRQ_MASK_RST = 3'h0;
	// Interrupt event bit positions
	localparam int EV_DISC = 0;
	localparam int EV_STAB = 1;
	localparam int EV_SEL = 2;
	localparam int EV_N = 3;
	// AHB transfer type with an active bit
	localparam int HTRANS_ACT_BIT = 1;

	// Software control bits
	typedef struct packed {
		logic fault_forces_off;
		logic basic_mode;
	} dsif_ctrl_s;

	// Live state shown to software
	typedef struct packed {
		logic std_filt;
		logic stab_fault;
		logic disc_fault;
		logic off_select;
		logic consistent;
		logic [1:0] pair_filt;
		logic [1:0] pair_sync;
	} dsif_state_s;

	// Stability monitor states
	typedef enum logic [0:0] {
		MON_IDLE,
		MON_RUN
	} dsif_mon_e;
endpackage : dsif_pkg
`default_nettype wire

/* logic/dsif_filter.sv */
// Operation
// - Pair consistent only when both channels equal
// - Short disagreement within tolerance raises nothing
// - Disagreement beyond tolerance signals wiring fault
// - Either channel falling selects torque-off at once
// - Nonzero debounce ignores changes shorter than it
// - Zero debounce follows every level change immediately
// - A pair change while idle starts five-tolerance monitoring timer
// - Stable means level held one tolerance before expiry
// - Basic mode faults when stability check fails
// - Standard and safe debounce settings stay independent
//
// Chosen here: the AHB-Lite register port and the register addresses.
`default_nettype none
module dsif_filter
	import dsif_pkg::*;
#(
	parameter logic [CNT_W-1:0] TOL_RESET = CNT_W'(DISC_TOL_RST_CYC),
	parameter logic [CNT_W-1:0] SAFE_DEB_RESET = CNT_W'(SAFE_DEB_RST_CYC),
	parameter logic [CNT_W-1:0] STD_DEB_RESET = CNT_W'(STD_DEB_RST_CYC)
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Fail-safe input pair and one standard input
	input wire logic [1:0] fail_safe_input_pair,
	input wire logic std_in,
	// Results
	output logic safe_torque_off,
	output logic discrepancy_fault,
	output logic stability_fault,
	output logic std_in_filt,
	output logic irq
);
	// Configuration registers
	dsif_ctrl_s ctrl_reg;
	logic [CNT_W-1:0] discrepancy_tolerance_time_reg;
	logic [CNT_W-1:0] safe_input_debounce_time_reg;
	logic [CNT_W-1:0] standard_input_debounce_time_reg;
	logic [EV_N-1:0] irq_stat_reg;
	logic [EV_N-1:0] irq_mask_reg;
	// Bus data phase capture
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic [31:0] hrdata_reg;
	// Synchroniser stages
	logic [1:0] pair_meta_reg;
	logic [1:0] pair_sync_reg;
	logic [1:0] std_meta_reg;
	// Debounced pair and its counters
	logic [1:0] pair_filt_reg;
	logic [CNT_W-1:0] deb_cnt_reg [2];
	// Standard input debounce
	logic std_filt_reg;
	logic [CNT_W-1:0] std_cnt_reg;
	// Discrepancy tracking
	logic [CNT_W-1:0] disc_cnt_reg;
	logic disc_fault_reg;
	// Stability monitor
	dsif_mon_e mon_state_reg;
	logic [MON_W-1:0] mon_cnt_reg;
	logic [CNT_W-1:0] hold_cnt_reg;
	logic stab_fault_reg;
	logic torque_off_prev_reg;
	// Combinational helpers
	logic addr_phase;
	logic consistent;
	logic [MON_W-1:0] mon_lim;
	logic [EV_N-1:0] events;
	dsif_state_s state;

	// Register read mux, shared by the read capture
	function automatic logic [31:0] rd_mux(input logic [7:0] a, input dsif_state_s s);
		if (a == CTRL_OFS) begin
			return {30'h0, ctrl_reg};
		end else if (a == TOL_OFS) begin
			return 32'(discrepancy_tolerance_time_reg);
		end else if (a == SDEB_OFS) begin
			return 32'(safe_input_debounce_time_reg);
		end else if (a == STDDEB_OFS) begin
			return 32'(standard_input_debounce_time_reg);
		end else if (a == STATE_OFS) begin
			return 32'(s);
		end else if (a == IRQ_STAT_OFS) begin
			return 32'(irq_stat_reg);
		end else if (a == IRQ_MASK_OFS) begin
			return 32'(irq_mask_reg);
		end else begin
			// Unmapped reads as zero
			return 32'h0;
		end
	endfunction : rd_mux

	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign addr_phase = hsel && htrans[HTRANS_ACT_BIT] && hready;

	// Address phase capture; read data is prepared for the data phase
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata_reg <= 32'h0;
		end else begin
			wr_pend_reg <= addr_phase && hwrite;
			if (addr_phase) begin
				wr_addr_reg <= haddr[7:0];
			end
			if (addr_phase && !hwrite) begin
				hrdata_reg <= rd_mux(haddr[7:0], state);
			end
		end
	end

	// Software writes in the data phase; hsize is ignored, whole words only
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= '{fault_forces_off: CTRL_FORCE_RST, basic_mode: CTRL_BASIC_RST};
			discrepancy_tolerance_time_reg <= TOL_RESET;
			safe_input_debounce_time_reg <= SAFE_DEB_RESET;
			standard_input_debounce_time_reg <= STD_DEB_RESET;
			irq_mask_reg <= IRQ_MASK_RST;
		end else if (wr_pend_reg) begin
			if (wr_addr_reg == CTRL_OFS) begin
				ctrl_reg <= hwdata[1:0];
			end else if (wr_addr_reg == TOL_OFS) begin
				discrepancy_tolerance_time_reg <= hwdata[CNT_W-1:0];
			end else if (wr_addr_reg == SDEB_OFS) begin
				safe_input_debounce_time_reg <= hwdata[CNT_W-1:0];
			end else if (wr_addr_reg == STDDEB_OFS) begin
				standard_input_debounce_time_reg <= hwdata[CNT_W-1:0];
			end else if (wr_addr_reg == IRQ_MASK_OFS) begin
				irq_mask_reg <= hwdata[EV_N-1:0];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pair_meta_reg <= 2'h0;
			pair_sync_reg <= 2'h0;
			std_meta_reg <= 2'h0;
		end else begin
			pair_meta_reg <= fail_safe_input_pair;
			pair_sync_reg <= pair_meta_reg;
			std_meta_reg <= {std_meta_reg[0], std_in};
		end
	end

	// Per-channel debounce of the safe pair
	for (genvar i = 0; i < 2; i++) begin : g_deb
		// Counts consecutive cycles that sync differs from filtered level
		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				pair_filt_reg[i] <= 1'b0;
				deb_cnt_reg[i] <= '0;
			end else if (safe_input_debounce_time_reg == '0) begin
				pair_filt_reg[i] <= pair_sync_reg[i];
				deb_cnt_reg[i] <= '0;
			end else if (pair_sync_reg[i] == pair_filt_reg[i]) begin
				deb_cnt_reg[i] <= '0;
			end else if (deb_cnt_reg[i] == safe_input_debounce_time_reg - 1'b1) begin
				pair_filt_reg[i] <= pair_sync_reg[i];
				deb_cnt_reg[i] <= '0;
			end else begin
				deb_cnt_reg[i] <= deb_cnt_reg[i] + 1'b1;
			end
		end
	end

	// standard input uses only its own debounce time
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			std_filt_reg <= 1'b0;
			std_cnt_reg <= '0;
		end else if (std_meta_reg[1] == std_filt_reg) begin
			std_cnt_reg <= '0;
		end else if (std_cnt_reg >= standard_input_debounce_time_reg) begin
			std_filt_reg <= std_meta_reg[1];
			std_cnt_reg <= '0;
		end else begin
			std_cnt_reg <= std_cnt_reg + 1'b1;
		end
	end

	assign consistent = pair_filt_reg[0] == pair_filt_reg[1];
	assign mon_lim = MON_W'(discrepancy_tolerance_time_reg) * MON_W'(MON_MULT);

	// Discrepancy timer; fault is a level while the disagreement lasts
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			disc_cnt_reg <= '0;
			disc_fault_reg <= 1'b0;
		end else if (consistent) begin
			disc_cnt_reg <= '0;
			disc_fault_reg <= 1'b0;
		end else if (disc_cnt_reg >= discrepancy_tolerance_time_reg) begin
			disc_fault_reg <= 1'b1;
		end else begin
			disc_cnt_reg <= disc_cnt_reg + 1'b1;
		end
	end

	// Previous filtered pair for change detection
	logic [1:0] pair_prev_reg;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pair_prev_reg <= 2'h0;
		end else begin
			pair_prev_reg <= pair_filt_reg;
		end
	end

	// Stability monitor; a change while running does not restart it,
	// otherwise a chattering input could postpone the verdict forever
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mon_state_reg <= MON_IDLE;
			mon_cnt_reg <= '0;
			hold_cnt_reg <= '0;
			stab_fault_reg <= 1'b0;
		end else begin
			case (mon_state_reg)
				MON_IDLE: begin
					if (pair_filt_reg != pair_prev_reg) begin
						mon_state_reg <= MON_RUN;
						mon_cnt_reg <= '0;
						hold_cnt_reg <= '0;
					end
				end
				MON_RUN: begin
					mon_cnt_reg <= mon_cnt_reg + 1'b1;
					if (pair_filt_reg != pair_prev_reg) begin
						hold_cnt_reg <= '0;
					end else if (hold_cnt_reg < discrepancy_tolerance_time_reg) begin
						hold_cnt_reg <= hold_cnt_reg + 1'b1;
					end
					if (hold_cnt_reg >= discrepancy_tolerance_time_reg &&
						pair_filt_reg == pair_prev_reg) begin
						mon_state_reg <= MON_IDLE;
						stab_fault_reg <= 1'b0;
					end else if (mon_cnt_reg >= mon_lim) begin
						mon_state_reg <= MON_IDLE;
						stab_fault_reg <= ctrl_reg.basic_mode;
					end
				end
				default: begin
					mon_state_reg <= MON_IDLE;
				end
			endcase
		end
	end

	// Live state word
	always_comb begin
		state.pair_sync = pair_sync_reg;
		state.pair_filt = pair_filt_reg;
		state.consistent = consistent;
		state.off_select = safe_torque_off;
		state.disc_fault = disc_fault_reg;
		state.stab_fault = stab_fault_reg;
		state.std_filt = std_filt_reg;
	end

	// any low channel selects, no tolerance delay
	assign safe_torque_off = (pair_filt_reg != 2'b11) ||
		(ctrl_reg.fault_forces_off && (disc_fault_reg || stab_fault_reg));
	assign discrepancy_fault = disc_fault_reg;
	assign stability_fault = stab_fault_reg;
	assign std_in_filt = std_filt_reg;

	// Rising edges of faults and selection form the events; selection
	// history starts high so leaving reset raises no false select event
	logic disc_prev_reg;
	logic stab_prev_reg;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			torque_off_prev_reg <= 1'b1;
			disc_prev_reg <= 1'b0;
			stab_prev_reg <= 1'b0;
		end else begin
			torque_off_prev_reg <= safe_torque_off;
			disc_prev_reg <= disc_fault_reg;
			stab_prev_reg <= stab_fault_reg;
		end
	end
	assign events = {safe_torque_off && !torque_off_prev_reg,
		stab_fault_reg && !stab_prev_reg,
		disc_fault_reg && !disc_prev_reg};

	// Sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			irq_stat_reg <= '0;
		end else if (wr_pend_reg && wr_addr_reg == IRQ_STAT_OFS) begin
			irq_stat_reg <= (irq_stat_reg & ~hwdata[EV_N-1:0]) | events;
		end else begin
			irq_stat_reg <= irq_stat_reg | events;
		end
	end
	assign irq = |(irq_stat_reg & irq_mask_reg);

	// Synchroniser depth
	a_sync_two_stage: assert property (@(posedge mclk) disable iff (!rst_b)
		$past(rst_b, 2) |-> pair_sync_reg == $past(fail_safe_input_pair, 2))
		else $error("sync depth wrong");
	// Consistent flag
	a_pair_consistent: assert property (@(posedge mclk) disable iff (!rst_b)
		pair_filt_reg[0] == pair_filt_reg[1] |=> !disc_fault_reg)
		else $error("consistency wrong");
	// No early discrepancy fault
	a_disc_not_early: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(disc_fault_reg) |-> $past(disc_cnt_reg) >= $past(discrepancy_tolerance_time_reg))
		else $error("discrepancy fault early");
	// Fault raises status bit
	a_disc_event: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(disc_fault_reg) |=> irq_stat_reg[EV_DISC])
		else $error("discrepancy event lost");
	// Immediate selection
	a_sel_no_delay: assert property (@(posedge mclk) disable iff (!rst_b)
		($fell(pair_filt_reg[0]) || $fell(pair_filt_reg[1])) |-> safe_torque_off)
		else $error("selection delayed");
	// Debounce full time
	a_deb_full_time: assert property (@(posedge mclk) disable iff (!rst_b)
		$changed(pair_filt_reg[0]) && $past(safe_input_debounce_time_reg) != '0 |->
		$past(deb_cnt_reg[0]) == $past(safe_input_debounce_time_reg) - 1'b1)
		else $error("debounce too short");
	// Zero debounce follows
	a_deb_bypass: assert property (@(posedge mclk) disable iff (!rst_b)
		$past(safe_input_debounce_time_reg) == '0 |-> pair_filt_reg == $past(pair_sync_reg))
		else $error("bypass lag");
	// Monitor bounded
	a_mon_bound: assert property (@(posedge mclk) disable iff (!rst_b)
		mon_state_reg == MON_RUN |-> mon_cnt_reg <= mon_lim)
		else $error("monitor overran");
	// Fault only at expiry
	a_stab_expiry: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(stab_fault_reg) |-> $past(mon_cnt_reg) >= $past(mon_lim) && $past(ctrl_reg.basic_mode))
		else $error("stability fault wrong");
endmodule : dsif_filter
`default_nettype wire

/* testbench/dsif_sensor.sv */
`default_nettype none
module dsif_sensor (
	// Clock
	input wire logic mclk,
	// Contact pair, channel 0 and channel 1
	output logic [1:0] pair
);
	timeunit 1ns;
	timeprecision 1ns;

	initial pair = 2'h3;

	task automatic set_ch(input int ch, input logic lvl);
		@(posedge mclk);
		pair[ch] <= lvl;
	endtask : set_ch

	// Both contacts switch on one edge
	task automatic set_pair(input logic [1:0] lvl);
		@(posedge mclk);
		pair <= lvl;
	endtask : set_pair

	// short test pulse, scaled below the debounce count
	task automatic blip(input int ch, input int len);
		@(posedge mclk);
		pair[ch] <= ~pair[ch];
		repeat (len) @(posedge mclk);
		pair[ch] <= ~pair[ch];
	endtask : blip
endmodule : dsif_sensor
`default_nettype wire

/* testbench/test_dual_channel_safe_input_filter.sv */
`default_nettype none
module test_dual_channel_safe_input_filter import dsif_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// Shortened counts so the run stays brief
	localparam int T = 8;
	localparam int D = 4;
	// Driven inputs
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic std_in = 1'b0;
	// Observed outputs
	logic hreadyout, hresp, torque_off, disc, stab, std_filt, irq, seen;
	logic [31:0] hrdata, rd;
	logic [1:0] pair;
	// Score keeping
	int error_cnt = 0;
	int checks = 0;
	// Model tables: register reset values, stability cases
	logic [7:0] ra[6] = '{CTRL_OFS, TOL_OFS, SDEB_OFS, STDDEB_OFS, IRQ_MASK_OFS, 8'h1c};
	logic [31:0] rv[6] = '{32'h3, 32'(T), 32'(D), 32'h3, 32'h0, 32'h0};
	// Last case keeps basic checking but lets a fault leave torque on
	int per[4] = '{T + 4, D + 2, D + 2, D + 2};
	logic [31:0] mode[4] = '{32'h3, 32'h3, 32'h2, 32'h1};
	logic [31:0] xstab[4] = '{32'h0, 32'h1, 32'h0, 32'h1};
	logic [31:0] xoff[4] = '{32'h0, 32'h1, 32'h0, 32'h0};

	// Free-running clock
	always #50 mclk = ~mclk;

	dsif_filter #(.TOL_RESET(CNT_W'(T)), .SAFE_DEB_RESET(CNT_W'(D)),
		.STD_DEB_RESET(CNT_W'(3))) i_dut (
		.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.fail_safe_input_pair(pair), .std_in(std_in), .safe_torque_off(torque_off),
		.discrepancy_fault(disc), .stability_fault(stab), .std_in_filt(std_filt),
		.irq(irq));

	dsif_sensor i_sensor (.mclk(mclk), .pair(pair));

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Wait edges, then let updates land
	task automatic at(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : at

	// One single AHB-Lite transfer; waits on hready, never a fixed count
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	// Verdict and end of run
	task automatic print_verdict;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : print_verdict

	// Hang guard, far beyond the expected run
	initial begin
		#2000000;
		error_cnt++;
		print_verdict();
	end

	// Main sequence
	initial begin
		void'($urandom(32'h8b6f5398));
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		at(80);
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, ra[i], 32'h0);
			chk(rd, rv[i]);
		end
		chk(32'(hresp), 32'h0);
		// read-only state of a consistent high pair
		bus(1'b1, STATE_OFS, 32'hffffffff);
		bus(1'b0, STATE_OFS, 32'h0);
		chk(rd, 32'h1f);
		bus(1'b1, IRQ_STAT_OFS, 32'h7);
		bus(1'b1, IRQ_MASK_OFS, 32'h1);
		// broken channel, prompt torque-off, late fault
		i_sensor.set_ch(0, 1'b0);
		at(D + 5);
		chk(32'(torque_off), 32'h1);
		chk(32'(disc), 32'h0);
		at(T + 4);
		chk(32'(disc), 32'h1);
		chk(32'(irq), 32'h1);
		bus(1'b0, IRQ_STAT_OFS, 32'h0);
		chk(rd, 32'h5);
		bus(1'b1, IRQ_STAT_OFS, 32'h1);
		at(1);
		chk(32'(irq), 32'h0);
		i_sensor.set_ch(0, 1'b1);
		at(60);
		chk(32'(disc), 32'h0);
		i_sensor.set_ch(0, 1'b0);
		at(3);
		i_sensor.set_ch(1, 1'b0);
		at(30);
		chk(32'(disc), 32'h0);
		chk(32'(torque_off), 32'h1);
		i_sensor.set_ch(1, 1'b1);
		at(2);
		i_sensor.set_ch(0, 1'b1);
		at(60);
		chk(32'(torque_off), 32'h0);
		// short pulses masked, standard debounce set to zero
		bus(1'b1, STDDEB_OFS, 32'h0);
		repeat (4) begin
			i_sensor.blip(0, 1 + int'($urandom % (D - 1)));
			repeat (10) begin
				at(1);
				chk(32'(torque_off), 32'h0);
			end
		end
		// toggle rate against the monitor window
		bus(1'b1, IRQ_MASK_OFS, 32'h2);
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, CTRL_OFS, mode[c]);
			bus(1'b1, IRQ_STAT_OFS, 32'h7);
			repeat (12) begin
				i_sensor.set_pair(~pair);
				at(per[c] - 1);
			end
			chk(32'(stab), xstab[c]);
			chk(32'(irq), xstab[c]);
			// Pair back high, fault still held: only the force bit selects
			at(3);
			chk(32'(torque_off), xoff[c]);
			at(60);
			chk(32'(stab), 32'h0);
		end
		bus(1'b1, CTRL_OFS, 32'h3);
		// zero debounce follows a one-cycle pulse
		bus(1'b1, SDEB_OFS, 32'h0);
		bus(1'b1, STDDEB_OFS, 32'h3);
		seen = 1'b0;
		i_sensor.blip(0, 1);
		repeat (5) begin
			at(1);
			if (torque_off === 1'b1) begin
				seen = 1'b1;
			end
		end
		chk(32'(seen), 32'h1);
		// standard input keeps its own debounce
		@(posedge mclk);
		std_in <= 1'b1;
		repeat (2) @(posedge mclk);
		std_in <= 1'b0;
		repeat (8) begin
			at(1);
			chk(32'(std_filt), 32'h0);
		end
		@(posedge mclk);
		std_in <= 1'b1;
		at(10);
		chk(32'(std_filt), 32'h1);
		print_verdict();
	end
endmodule : test_dual_channel_safe_input_filter
`default_nettype wire
